// ### src/otm_output_mux.sv
`timescale 1ns/1ns
module otm_output_mux import otm_pkg::*; #(
    parameter int ANALOG_W = 12,
    parameter int PULSE_CNT_W = 20,
    parameter int PLC_PULSE_CYC = OTM_PLC_PULSE_CYC
) (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [2:0] HSIZE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    output logic [31:0] HRDATA_OUT,
    output logic HREADYOUT_OUT,
    output logic HRESP_OUT,
    input wire otm_cond_s COND_IN,
    input wire logic [ANALOG_W-1:0] ANALOG_INPUT_ONE_IN,
    input wire logic [ANALOG_W-1:0] ANALOG_INPUT_TWO_IN,
    output logic SHARED_MULTIPLEX_TERMINAL_OUT,
    output logic RELAY_OUT,
    output logic SECOND_SWITCH_OUTPUT_OUT
);

    localparam int PLC_W = $clog2(PLC_PULSE_CYC + 1);

    if (PULSE_CNT_W < $clog2(OTM_PULSE_MIN_PERIOD_CYC + 1) || PULSE_CNT_W > 32) begin : g_chk_pw
        $error("PULSE_CNT_W cannot hold the shortest pulse period.");
    end
    if (PLC_PULSE_CYC < 1 || ANALOG_W < 1 || ANALOG_W > 32) begin : g_chk_misc
        $error("PLC_PULSE_CYC or ANALOG_W out of range.");
    end

    typedef struct packed {
        logic mode;
        logic [5:0] shared_code;
        logic [5:0] relay_code;
        logic [5:0] second_code;
        logic [2:0] comm_value;
        logic [PULSE_CNT_W-1:0] pulse_period;
        logic [PULSE_CNT_W-1:0] pulse_cnt;
        logic [PLC_W-1:0] plc_cnt;
        logic plc_active;
        logic dph_write;
        logic [7:0] dph_addr;
        logic [31:0] rdata;
        logic readyout;
        logic shared_out;
        logic relay_out;
        logic second_out;
        logic resp;
    } otm_state_s;

    otm_state_s s_q;
    otm_state_s s_d;

    // Codes above 20 are reserved or not carried by this block and read as off.
    function automatic logic otm_select(input logic [5:0] code, input logic [19:0] vec,
            input logic comm);
        logic r;
        r = 1'b0;
        if (code == 6'h14) begin
            r = comm;
        end else if (code <= OTM_CODE_LAST_IMPL) begin
            r = vec[code[4:0]];
        end
        return r;
    endfunction

    function automatic logic [5:0] otm_code_wr(input logic [5:0] old, input logic [31:0] wd);
        logic [5:0] r;
        r = old;
        if (wd[31:6] == 26'h0 && wd[5:0] <= OTM_CODE_MAX) begin
            r = wd[5:0];
        end
        return r;
    endfunction

    logic [19:0] cond_vec;
    logic [PULSE_CNT_W-1:0] eff_period;
    logic pulse_level;
    logic take;

    always_comb begin
        cond_vec = 20'h0;
        cond_vec[0] = 1'b0;
        cond_vec[1] = COND_IN.running;
        cond_vec[2] = COND_IN.fault_stop;
        cond_vec[3] = COND_IN.freq_level_detect_one;
        cond_vec[4] = COND_IN.freq_arrival;
        cond_vec[5] = COND_IN.running & COND_IN.out_freq_zero;
        cond_vec[6] = COND_IN.motor_ovl_prealarm;
        cond_vec[7] = COND_IN.drive_ovl_trip_10s;
        cond_vec[8] = COND_IN.count_set_reached;
        cond_vec[9] = COND_IN.count_designated_reached;
        cond_vec[10] = COND_IN.length_exceeded;
        cond_vec[11] = s_q.plc_active;
        cond_vec[12] = COND_IN.accum_run_exceeded;
        cond_vec[13] = COND_IN.set_freq_beyond_limit
            & (COND_IN.out_freq_at_upper | COND_IN.out_freq_at_lower);
        cond_vec[14] = COND_IN.speed_mode & COND_IN.torque_at_limit
            & COND_IN.stall_active;
        cond_vec[15] = COND_IN.main_supply_ok & COND_IN.ctrl_supply_ok
            & ~COND_IN.fault_detected & COND_IN.operable;
        cond_vec[16] = ANALOG_INPUT_ONE_IN > ANALOG_INPUT_TWO_IN;
        cond_vec[17] = COND_IN.out_freq_at_upper;
        cond_vec[18] = COND_IN.out_freq_at_lower & COND_IN.running;
        cond_vec[19] = COND_IN.under_voltage;
    end

    // A nonzero requested period shorter than the minimum is stretched, so a bad setting
    // slows the pulse train rather than overdriving the terminal.
    always_comb begin
        eff_period = s_q.pulse_period;
        if (s_q.pulse_period != '0
                && s_q.pulse_period < PULSE_CNT_W'(OTM_PULSE_MIN_PERIOD_CYC)) begin
            eff_period = PULSE_CNT_W'(OTM_PULSE_MIN_PERIOD_CYC);
        end
        pulse_level = (eff_period != '0) && (s_q.pulse_cnt < (eff_period >> 1));
    end

    assign take = HSEL_IN & HREADY_IN & (HTRANS_IN == OTM_HTRANS_NONSEQ);

    always_comb begin
        s_d = s_q;
        s_d.readyout = 1'b1;
        s_d.resp = OTM_HRESP_OKAY;
        // Writes land first so that a read right behind a write sees the new value.
        if (s_q.dph_write) begin
            case (s_q.dph_addr)
                OTM_ADDR_MODE: s_d.mode = HWDATA_IN[0];
                OTM_ADDR_SHARED_CODE: s_d.shared_code = otm_code_wr(s_q.shared_code, HWDATA_IN);
                OTM_ADDR_RELAY_CODE: s_d.relay_code = otm_code_wr(s_q.relay_code, HWDATA_IN);
                OTM_ADDR_SECOND_CODE: s_d.second_code = otm_code_wr(s_q.second_code, HWDATA_IN);
                OTM_ADDR_COMM_VALUE: s_d.comm_value = HWDATA_IN[2:0];
                OTM_ADDR_PULSE_PERIOD: s_d.pulse_period = HWDATA_IN[PULSE_CNT_W-1:0];
                default: s_d.mode = s_q.mode;
            endcase
        end
        s_d.dph_write = take & HWRITE_IN;
        s_d.dph_addr = HADDR_IN[7:0];
        s_d.rdata = 32'h0;
        if (take && !HWRITE_IN) begin
            case (HADDR_IN[7:0])
                OTM_ADDR_MODE: s_d.rdata = {31'h0, s_d.mode};
                OTM_ADDR_SHARED_CODE: s_d.rdata = {26'h0, s_d.shared_code};
                OTM_ADDR_RELAY_CODE: s_d.rdata = {26'h0, s_d.relay_code};
                OTM_ADDR_SECOND_CODE: s_d.rdata = {26'h0, s_d.second_code};
                OTM_ADDR_COMM_VALUE: s_d.rdata = {29'h0, s_d.comm_value};
                OTM_ADDR_PULSE_PERIOD: s_d.rdata = 32'(s_d.pulse_period);
                OTM_ADDR_STATUS: begin
                    s_d.rdata[OTM_STATUS_OUT_POS +: 3] =
                        {s_q.second_out, s_q.relay_out, s_q.shared_out};
                    s_d.rdata[OTM_STATUS_PLC_POS] = s_q.plc_active;
                    s_d.rdata[OTM_STATUS_COND_POS +: 20] = cond_vec;
                end
                default: s_d.rdata = 32'h0;
            endcase
        end

        // A new cycle completion restarts the full pulse width.
        if (COND_IN.plc_cycle_done) begin
            s_d.plc_cnt = PLC_W'(PLC_PULSE_CYC - 1);
            s_d.plc_active = 1'b1;
        end else if (s_q.plc_cnt != '0) begin
            s_d.plc_cnt = s_q.plc_cnt - PLC_W'(1);
        end else begin
            s_d.plc_active = 1'b0;
        end

        if (s_q.mode || eff_period == '0 || s_q.pulse_cnt >= eff_period - PULSE_CNT_W'(1)) begin
            s_d.pulse_cnt = '0;
        end else begin
            s_d.pulse_cnt = s_q.pulse_cnt + PULSE_CNT_W'(1);
        end

        if (s_q.mode) begin
            s_d.shared_out = otm_select(s_q.shared_code, cond_vec, s_q.comm_value[0]);
        end else begin
            s_d.shared_out = pulse_level;
        end
        s_d.relay_out = otm_select(s_q.relay_code, cond_vec, s_q.comm_value[1]);
        s_d.second_out = otm_select(s_q.second_code, cond_vec, s_q.comm_value[2]);
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            s_q <= '0;
            s_q.mode <= OTM_RST_MODE;
            s_q.shared_code <= OTM_RST_SHARED_CODE;
            s_q.relay_code <= OTM_RST_RELAY_CODE;
            s_q.second_code <= OTM_RST_SECOND_CODE;
            s_q.comm_value <= OTM_RST_COMM_VALUE;
            s_q.readyout <= 1'b1;
            s_q.resp <= OTM_HRESP_OKAY;
        end else begin
            s_q <= s_d;
        end
    end

    assign HRDATA_OUT = s_q.rdata;
    assign HREADYOUT_OUT = s_q.readyout;
    assign HRESP_OUT = s_q.resp;
    assign SHARED_MULTIPLEX_TERMINAL_OUT = s_q.shared_out;
    assign RELAY_OUT = s_q.relay_out;
    assign SECOND_SWITCH_OUTPUT_OUT = s_q.second_out;

endmodule

// ### src/otm_pkg.sv
// Behaviour
// - Shared terminal: mode 0 pulse, 1 switch.
// - Pulse output never exceeds 100 kHz.
// - Switch mode uses its own function code.
// - Three codes 0..42; relay defaults 2.
// - Code 0 keeps output off.
// - Code 1: on while running, even zero.
// - Code 2: on after fault stop.
// - Code 5: running at zero frequency only.
// - Code 6: motor overload pre-alarm exceeded.
// - Code 7: drive overload trip in 10s.
// - Codes 8, 9: set or designated count.
// - Code 10: actual length exceeds target.
// - Code 11: 250 ms pulse per cycle.
// - Code 12: accumulated run time exceeded.
// - Code 13: set beyond limit, output at limit.
// - Code 14: speed mode torque limit stall.
// - Code 15: supplies settled, no fault, operable.
// - Code 16: first analog above second analog.
// - Code 17: operating frequency at upper limit.
// - Code 18: at lower limit, off stopped.
// - Code 19: under-voltage state.
// - Code 20: follow communication-written value.
package otm_pkg;

    localparam logic [7:0] OTM_ADDR_MODE = 8'h00;
    localparam logic [7:0] OTM_ADDR_SHARED_CODE = 8'h04;
    localparam logic [7:0] OTM_ADDR_RELAY_CODE = 8'h08;
    localparam logic [7:0] OTM_ADDR_SECOND_CODE = 8'h0c;
    localparam logic [7:0] OTM_ADDR_COMM_VALUE = 8'h10;
    localparam logic [7:0] OTM_ADDR_PULSE_PERIOD = 8'h14;
    localparam logic [7:0] OTM_ADDR_STATUS = 8'h18;

    localparam int OTM_CODE_W = 6;
    localparam logic [5:0] OTM_CODE_MAX = 6'h2a;
    localparam logic [5:0] OTM_CODE_LAST_IMPL = 6'h14;
    localparam logic OTM_RST_MODE = 1'h0;
    localparam logic [5:0] OTM_RST_SHARED_CODE = 6'h00;
    localparam logic [5:0] OTM_RST_RELAY_CODE = 6'h02;
    localparam logic [5:0] OTM_RST_SECOND_CODE = 6'h00;
    localparam logic [2:0] OTM_RST_COMM_VALUE = 3'h0;

    localparam int OTM_STATUS_OUT_POS = 0;
    localparam int OTM_STATUS_PLC_POS = 3;
    localparam int OTM_STATUS_COND_POS = 4;

    localparam longint OTM_CLK_HZ = 20000000;
    localparam longint OTM_PULSE_MAX_HZ = 100000;
    localparam int OTM_PULSE_MIN_PERIOD_CYC = int'((OTM_CLK_HZ + OTM_PULSE_MAX_HZ - 1)
        / OTM_PULSE_MAX_HZ);
    localparam longint OTM_PLC_PULSE_MS = 250;
    localparam int OTM_PLC_PULSE_CYC = int'(OTM_PLC_PULSE_MS * OTM_CLK_HZ / 1000);

    localparam logic [1:0] OTM_HTRANS_NONSEQ = 2'h2;
    localparam logic OTM_HRESP_OKAY = 1'h0;

    typedef struct packed {
        logic running;
        logic out_freq_zero;
        logic fault_stop;
        logic fault_detected;
        logic freq_level_detect_one;
        logic freq_arrival;
        logic motor_ovl_prealarm;
        logic drive_ovl_trip_10s;
        logic count_set_reached;
        logic count_designated_reached;
        logic length_exceeded;
        logic plc_cycle_done;
        logic accum_run_exceeded;
        logic set_freq_beyond_limit;
        logic out_freq_at_upper;
        logic out_freq_at_lower;
        logic speed_mode;
        logic torque_at_limit;
        logic stall_active;
        logic main_supply_ok;
        logic ctrl_supply_ok;
        logic operable;
        logic under_voltage;
    } otm_cond_s;

endpackage

// ### bench/otm_loads.sv
`timescale 1ns/1ns
module otm_loads (
    input wire logic clk_in,
    input wire logic [2:0] drive_in,
    output logic [2:0] energised_out
);
    // Coils pull in a clock late; the load follows the drive as sampled on each rising edge.
    always_ff @(posedge clk_in) begin
        energised_out <= drive_in;
    end
endmodule

// ### bench/otm_output_mux_chk.sv
`timescale 1ns/1ns
module otm_output_mux_chk import otm_pkg::*; #(
    parameter int ANALOG_W = 12
) (
    input wire logic CLK_SYS_IN,
    input wire logic SYS_RST_IN,
    input wire logic HSEL_IN,
    input wire logic [31:0] HADDR_IN,
    input wire logic [1:0] HTRANS_IN,
    input wire logic HWRITE_IN,
    input wire logic [31:0] HWDATA_IN,
    input wire logic HREADY_IN,
    input wire otm_cond_s COND_IN,
    input wire logic [ANALOG_W-1:0] ANALOG_INPUT_ONE_IN,
    input wire logic [ANALOG_W-1:0] ANALOG_INPUT_TWO_IN,
    input wire logic SHARED_MULTIPLEX_TERMINAL_OUT,
    input wire logic RELAY_OUT
);
    // Bus writes are snooped, so the relay code and mode are known here.
    logic wr_q, md_q, sh_q, seen_q, ok;
    logic [7:0] wa_q, cnt_q;
    logic [5:0] rc_q, rcp_q;
    logic [1:0] rst_q;
    assign ok = (rc_q == rcp_q) && (rst_q == 2'h0);
    always_ff @(posedge CLK_SYS_IN) begin
        wr_q <= HSEL_IN && HREADY_IN && HTRANS_IN == OTM_HTRANS_NONSEQ && HWRITE_IN;
        wa_q <= HADDR_IN[7:0];
        rst_q <= {rst_q[0], SYS_RST_IN};
        rcp_q <= rc_q;
        sh_q <= SHARED_MULTIPLEX_TERMINAL_OUT;
        if (SYS_RST_IN) begin
            rc_q <= OTM_RST_RELAY_CODE;
            md_q <= OTM_RST_MODE;
        end else if (wr_q && wa_q == OTM_ADDR_RELAY_CODE && HWDATA_IN <= 32'h2a) begin
            rc_q <= HWDATA_IN[5:0];
        end else if (wr_q && wa_q == OTM_ADDR_MODE) begin
            md_q <= HWDATA_IN[0];
        end
        if (SYS_RST_IN || md_q) begin
            seen_q <= 1'h0;
            cnt_q <= 8'h00;
        end else if (SHARED_MULTIPLEX_TERMINAL_OUT && !sh_q) begin
            seen_q <= 1'h1;
            cnt_q <= 8'h00;
        end else if (cnt_q != 8'hff) begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);
    a_pulse_rate_max: assert property (
        !md_q && seen_q && SHARED_MULTIPLEX_TERMINAL_OUT && !sh_q |-> cnt_q >= 8'hc7)
        else $error("Pulse period too short.");
    a_code_zero_off: assert property (ok && rc_q == 6'h00 |-> !RELAY_OUT)
        else $error("Code 0 output active.");
    a_code_run: assert property (
        ok && rc_q == 6'h01 |-> RELAY_OUT == $past(COND_IN.running))
        else $error("Code 1 output wrong.");
    a_fault_stop: assert property (
        ok && rc_q == 6'h02 |-> RELAY_OUT == $past(COND_IN.fault_stop))
        else $error("Code 2 output wrong.");
    a_zero_speed: assert property (
        ok && rc_q == 6'h05
        |-> RELAY_OUT == ($past(COND_IN.running) && $past(COND_IN.out_freq_zero)))
        else $error("Code 5 output wrong.");
    a_analog_cmp: assert property (
        ok && rc_q == 6'h10
        |-> RELAY_OUT == ($past(ANALOG_INPUT_ONE_IN) > $past(ANALOG_INPUT_TWO_IN)))
        else $error("Code 16 output wrong.");
    a_lower_limit: assert property (
        ok && rc_q == 6'h12
        |-> RELAY_OUT == ($past(COND_IN.running) && $past(COND_IN.out_freq_at_lower)))
        else $error("Code 18 output wrong.");
    a_under_volt: assert property (
        ok && rc_q == 6'h13 |-> RELAY_OUT == $past(COND_IN.under_voltage))
        else $error("Code 19 output wrong.");
    a_reserved_off: assert property (ok && rc_q > 6'h14 |-> !RELAY_OUT)
        else $error("Reserved code output active.");
endmodule

bind otm_output_mux otm_output_mux_chk #(.ANALOG_W(ANALOG_W)) u_chk (
    .CLK_SYS_IN(CLK_SYS_IN), .SYS_RST_IN(SYS_RST_IN), .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN),
    .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN),
    .COND_IN(COND_IN), .ANALOG_INPUT_ONE_IN(ANALOG_INPUT_ONE_IN),
    .ANALOG_INPUT_TWO_IN(ANALOG_INPUT_TWO_IN), .RELAY_OUT(RELAY_OUT),
    .SHARED_MULTIPLEX_TERMINAL_OUT(SHARED_MULTIPLEX_TERMINAL_OUT));

// ### bench/otm_output_mux_test.sv
`timescale 1ns/1ns
module otm_output_mux_test;
    import otm_pkg::*;
    localparam int PLC_CYC = 20;
    localparam logic H = 1'h1;
    localparam logic L = 1'h0;
    logic clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, hready, hresp;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [11:0] an1 = 12'h000, an2 = 12'h000;
    logic [2:0] outs, loads;
    otm_cond_s cond = '0;
    int errors = 0, samples_checked = 0;
    otm_output_mux #(.PLC_PULSE_CYC(PLC_CYC)) DUT (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr),
        .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
        .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
        .COND_IN(cond), .ANALOG_INPUT_ONE_IN(an1), .ANALOG_INPUT_TWO_IN(an2),
        .SHARED_MULTIPLEX_TERMINAL_OUT(outs[0]), .RELAY_OUT(outs[1]),
        .SECOND_SWITCH_OUTPUT_OUT(outs[2]));
    otm_loads LOADS (.clk_in(clk), .drive_in(outs), .energised_out(loads));
    task automatic print_verdict();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= OTM_HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'h1);
        r = hrdata;
        cmp({31'h0, hresp}, {31'h0, OTM_HRESP_OKAY});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        cmp(r, e);
    endtask
    // Bounded wait on one terminal; the count is the cycles spent waiting.
    task automatic wt(input int k, input logic v, output int n);
        n = 0;
        while (outs[k] !== v && n < 1000) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic tc(input logic [5:0] c, input otm_cond_s s, input logic e);
        @(posedge clk);
        cond <= s;
        wr(OTM_ADDR_RELAY_CODE, {26'h0, c});
        repeat (3) @(posedge clk);
        cmp({31'h0, outs[1]}, {31'h0, e});
    endtask
    task automatic t_reset();
        rd(OTM_ADDR_MODE, 32'h0);
        rd(OTM_ADDR_SHARED_CODE, 32'h0);
        rd(OTM_ADDR_RELAY_CODE, 32'h2);
        rd(OTM_ADDR_SECOND_CODE, 32'h0);
        rd(8'h40, 32'h0);
    endtask
    task automatic t_pulse();
        int hi, lo;
        wr(OTM_ADDR_PULSE_PERIOD, 32'ha);
        wt(0, H, hi);
        wt(0, L, hi);
        wt(0, H, lo);
        cmp(32'(hi), 32'(OTM_CLK_HZ / OTM_PULSE_MAX_HZ / 2));
        cmp(32'(hi + lo), 32'(OTM_CLK_HZ / OTM_PULSE_MAX_HZ));
    endtask
    task automatic t_codes();
        tc(6'h00, '1, L);
        tc(6'h01, '{running: H, out_freq_zero: H, default: L}, H);
        tc(6'h2b, '{running: H, default: L}, H);
        tc(6'h02, '{fault_stop: H, default: L}, H);
        tc(6'h05, '{running: H, out_freq_zero: H, default: L}, H);
        tc(6'h05, '{out_freq_zero: H, default: L}, L);
        tc(6'h06, '{motor_ovl_prealarm: H, default: L}, H);
        tc(6'h07, '{drive_ovl_trip_10s: H, default: L}, H);
        tc(6'h08, '{count_set_reached: H, default: L}, H);
        tc(6'h09, '{count_set_reached: H, default: L}, L);
        tc(6'h0a, '{length_exceeded: H, default: L}, H);
        tc(6'h0c, '{accum_run_exceeded: H, default: L}, H);
        tc(6'h0d, '{set_freq_beyond_limit: H, out_freq_at_lower: H, default: L}, H);
        tc(6'h0d, '{out_freq_at_upper: H, default: L}, L);
        tc(6'h0e, '{speed_mode: H, torque_at_limit: H, stall_active: H, default: L}, H);
        tc(6'h0f, '{main_supply_ok: H, ctrl_supply_ok: H, operable: H, default: L}, H);
        tc(6'h0f, '{fault_detected: H, default: H}, L);
        an1 <= 12'h801;
        an2 <= 12'h800;
        tc(6'h10, '0, H);
        an1 <= 12'h800;
        tc(6'h10, '0, L);
        tc(6'h11, '{out_freq_at_upper: H, default: L}, H);
        tc(6'h12, '{out_freq_at_lower: H, default: L}, L);
        tc(6'h12, '{running: H, out_freq_at_lower: H, default: L}, H);
        tc(6'h13, '{under_voltage: H, default: L}, H);
        wr(OTM_ADDR_COMM_VALUE, 32'h2);
        tc(6'h14, '0, H);
        wr(OTM_ADDR_COMM_VALUE, 32'h5);
        tc(6'h14, '1, L);
        tc(6'h19, '1, L);
    endtask
    task automatic t_switch();
        wr(OTM_ADDR_MODE, 32'h1);
        wr(OTM_ADDR_SHARED_CODE, 32'h13);
        wr(OTM_ADDR_SECOND_CODE, 32'h1);
        tc(6'h00, '{under_voltage: H, running: H, default: L}, L);
        cmp({29'h0, loads}, 32'h5);
        tc(6'h00, '{running: H, default: L}, L);
        cmp({29'h0, loads}, 32'h4);
    endtask
    task automatic t_plc();
        int n;
        // The relay drops one edge after the pulse ends and is seen one edge later.
        tc(6'h0b, '{plc_cycle_done: H, default: L}, H);
        cond <= '0;
        wt(1, L, n);
        cmp(32'(n), 32'(PLC_CYC + 2));
        tc(6'h0b, '{plc_cycle_done: H, default: L}, H);
        cond <= '0;
        wt(1, L, n);
        cmp(32'(n), 32'(PLC_CYC + 2));
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_pulse();
        t_codes();
        t_switch();
        t_plc();
        print_verdict();
    end
    // The whole sequence needs well under a thousand cycles; this is a generous margin.
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule
